// file: design/idle_frame_rate_and_booster_clock_cfg.v
/*
 * Command/parameter register block for idle frame timing and normal-mode
 * charge-pump and amplifier bias selection, plus a line/frame timer.
 * Assumes host pins arrive synchronous to mclk; the write strobe is sampled
 * and its rising edge detected here. One parameter byte per command.
 */
// Notes on behaviour
// - Idle inversion bit: 0 column, 1 dot
// - Idle porch 13 bits, minimum 0x04; lower values are accepted, flagged and still used
// - Idle divider codes 28h..FFh only; lower codes are accepted and flagged, and the timer clamps them to 28h
// - Frame period from lines, porch, divider, tcon
// - Reference 390 lines, porch 20h, tcon 400
// - Writes accepted in every operating state
// - Neg gate pump clock 9/6.67/5/4.5 MHz
// - Aux pos gate pump 6.67/6/5/4.5 MHz
// - Pos gate pump 6.67/6/5/4.5 MHz
// - Analog pump clock 18/13/10/5 MHz
// - Neg analog pump 13/10/5 for 1..3
// - Output bias 0.1x to 0.4x
// - Input bias bits 6:4, bit 7 ignored
// - Neg analog pump code 0 gives 18 MHz
// - Input bias stop, then 1.0x..4.0x steps
`timescale 1ns/100ps
`include "idle_timing_regs.vh"

module idle_frame_rate_and_booster_clock_cfg #(
    parameter PANEL_LINES = `PANEL_LINES,
    parameter TCON_DIV = 4
) (
    input wire mclk,
    input wire sys_rst,
    input wire cmd_param_select,
    input wire write_strobe_n,
    input wire [7:0] data_in,
    input wire idle_mode,
    output reg dot_inversion,
    output reg [12:0] porch_length,
    output reg [7:0] line_divider,
    output reg setting_illegal,
    output reg line_tick,
    output reg frame_tick,
    output reg [1:0] neg_gate_pump_clock_sel,
    output reg [1:0] aux_pos_gate_pump_clock_sel,
    output reg [1:0] pos_gate_pump_clock_sel,
    output reg [1:0] analog_pump_clock_sel,
    output reg [1:0] neg_analog_pump_clock_sel,
    output reg [2:0] amp_input_bias_sel,
    output reg [1:0] amp_output_bias_sel,
    output reg [7:0] neg_gate_pump_khz_div,
    output reg [7:0] analog_pump_code_mhz,
    output reg [5:0] amp_input_bias_half_x,
    output reg [2:0] amp_output_bias_tenth_x
);

    // ****************************************************************
    // Host write capture
    // ****************************************************************
    reg strobe_q;
    reg [7:0] cur_cmd;
    reg cmd_valid;
    reg [7:0] idle_inversion_porch_high;
    reg [7:0] idle_porch_low;
    reg [7:0] idle_line_divider;
    reg [7:0] normal_gate_pump_clocks;
    reg [7:0] normal_bias_and_neg_pump;
    wire strobe_rise;

    // A strobe low or high for under one mclk period can be missed
    assign strobe_rise = write_strobe_n & ~strobe_q;

    // Command byte selects target; the one parameter byte lands there.
    // No mode gating here: writes land in sleep, idle, partial alike.
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            strobe_q <= 1'b1;
            cur_cmd <= 8'h00;
            cmd_valid <= 1'b0;
            idle_inversion_porch_high <= `RST_IDLE_INV_PORCH_HIGH;
            idle_porch_low <= `RST_IDLE_PORCH_LOW;
            idle_line_divider <= `RST_IDLE_LINE_DIVIDER;
            normal_gate_pump_clocks <= `RST_NORMAL_GATE_PUMP;
            normal_bias_and_neg_pump <= `RST_NORMAL_BIAS_NEG_PUMP;
        end else begin
            strobe_q <= write_strobe_n;
            if (strobe_rise && !cmd_param_select) begin
                cur_cmd <= data_in;
                cmd_valid <= 1'b1;
            end else if (strobe_rise && cmd_valid) begin
                // Only a single parameter follows; later bytes are dropped
                cmd_valid <= 1'b0;
                case (cur_cmd)
                    `CMD_IDLE_INV_PORCH_HIGH: begin
                        idle_inversion_porch_high <= data_in;
                    end
                    `CMD_IDLE_PORCH_LOW: begin
                        idle_porch_low <= data_in;
                    end
                    `CMD_IDLE_LINE_DIVIDER: begin
                        idle_line_divider <= data_in;
                    end
                    `CMD_NORMAL_GATE_PUMP: begin
                        normal_gate_pump_clocks <= data_in;
                    end
                    `CMD_NORMAL_BIAS_NEG_PUMP: begin
                        normal_bias_and_neg_pump <= data_in;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // ****************************************************************
    // Active setting selection
    // ****************************************************************
    reg next_dot;
    reg [12:0] next_porch;
    reg [7:0] next_divider;

    // Idle fields apply only in idle mode; otherwise normal defaults
    always @* begin
        if (idle_mode) begin
            next_dot = idle_inversion_porch_high[`F_INV_SEL];
            next_porch = {idle_inversion_porch_high[`F_PORCH_HI_MSB:0],
                          idle_porch_low};
            next_divider = idle_line_divider;
        end else begin
            next_dot = 1'b1;
            next_porch = `NORMAL_PORCH_DEFAULT;
            next_divider = `NORMAL_DIVIDER_DEFAULT;
        end
    end

    // ****************************************************************
    // Frame timer
    // ****************************************************************
    // A line lasts divider * tcon periods; a frame 2*lines + 2*porch lines.
    // TCON_DIV stands in for the timing-controller clock ratio to mclk.
    reg [7:0] tcon_cnt;
    reg [7:0] div_cnt;
    reg [14:0] line_cnt;
    wire [14:0] frame_lines;
    wire [7:0] eff_divider;
    wire next_illegal;

    // The end points are compared live, so the frame in which a setting
    // changes may run short or long; the frame after it is exact.
    // Both terms are doubled by a shift; the sum needs all fifteen bits.
    assign frame_lines = {PANEL_LINES[13:0], 1'b0} +
                         {1'b0, porch_length, 1'b0};
    // Illegal divider codes are clamped so the timer never stalls at zero
    assign eff_divider = (line_divider < `MIN_LINE_DIVIDER) ?
                         `MIN_LINE_DIVIDER : line_divider;
    // Out-of-range settings still reach the outputs, though the timer clamps a low divider; the flag reports them
    assign next_illegal = (next_porch < `MIN_PORCH) ||
                          (next_divider < `MIN_LINE_DIVIDER);

    // Timer and registered outputs
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tcon_cnt <= 8'h00;
            div_cnt <= 8'h00;
            line_cnt <= 15'h0000;
            line_tick <= 1'b0;
            frame_tick <= 1'b0;
            dot_inversion <= 1'b1;
            porch_length <= `NORMAL_PORCH_DEFAULT;
            line_divider <= `NORMAL_DIVIDER_DEFAULT;
            setting_illegal <= 1'b0;
        end else begin
            dot_inversion <= next_dot;
            porch_length <= next_porch;
            line_divider <= next_divider;
            setting_illegal <= next_illegal;
            line_tick <= 1'b0;
            frame_tick <= 1'b0;
            if (tcon_cnt >= TCON_DIV[7:0] - 8'h01) begin
                tcon_cnt <= 8'h00;
                if (div_cnt >= eff_divider - 8'h01) begin
                    div_cnt <= 8'h00;
                    line_tick <= 1'b1;
                    if (line_cnt >= frame_lines - 15'h0001) begin
                        line_cnt <= 15'h0000;
                        frame_tick <= 1'b1;
                    end else begin
                        line_cnt <= line_cnt + 15'h0001;
                    end
                end else begin
                    div_cnt <= div_cnt + 8'h01;
                end
            end else begin
                tcon_cnt <= tcon_cnt + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Pump clock and bias decode
    // ****************************************************************
    reg [7:0] next_neg_gate;
    reg [7:0] next_analog;
    reg [5:0] next_in_bias;
    wire [1:0] neg_gate_code;
    wire [1:0] analog_code;
    wire [2:0] in_bias_code;

    assign neg_gate_code = normal_gate_pump_clocks[`F_NEG_GATE_MSB:`F_NEG_GATE_LSB];
    assign analog_code = normal_gate_pump_clocks[`F_ANALOG_MSB:`F_ANALOG_LSB];
    assign in_bias_code = normal_bias_and_neg_pump[`F_IN_BIAS_MSB:`F_IN_BIAS_LSB];

    // Frequencies in tenths of MHz for the neg gate pump, MHz for analog
    always @* begin
        case (neg_gate_code)
            2'h0: begin
                next_neg_gate = 8'h5a;
            end
            2'h1: begin
                next_neg_gate = 8'h43;
            end
            2'h2: begin
                next_neg_gate = 8'h32;
            end
            default: begin
                next_neg_gate = 8'h2d;
            end
        endcase
        case (analog_code)
            2'h0: begin
                next_analog = 8'h12;
            end
            2'h1: begin
                next_analog = 8'h0d;
            end
            2'h2: begin
                next_analog = 8'h0a;
            end
            default: begin
                next_analog = 8'h05;
            end
        endcase
        // Code 0 stops the bias; code n gives (n+1)/2 x, counted in halves
        if (in_bias_code == 3'h0) begin
            next_in_bias = 6'h00;
        end else begin
            next_in_bias = {3'h0, in_bias_code} + 6'h01;
        end
    end

    // ****************************************************************
    // Registered select outputs
    // ****************************************************************
    // Raw selects go out registered; bit 7 of the bias register is unused
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            neg_gate_pump_clock_sel <= 2'h2;
            aux_pos_gate_pump_clock_sel <= 2'h2;
            pos_gate_pump_clock_sel <= 2'h2;
            analog_pump_clock_sel <= 2'h1;
            neg_analog_pump_clock_sel <= 2'h1;
            amp_input_bias_sel <= 3'h4;
            amp_output_bias_sel <= 2'h0;
        end else begin
            neg_gate_pump_clock_sel <= neg_gate_code;
            aux_pos_gate_pump_clock_sel <=
                normal_gate_pump_clocks[`F_AUX_POS_MSB:`F_AUX_POS_LSB];
            pos_gate_pump_clock_sel <=
                normal_gate_pump_clocks[`F_POS_GATE_MSB:`F_POS_GATE_LSB];
            analog_pump_clock_sel <= analog_code;
            neg_analog_pump_clock_sel <=
                normal_bias_and_neg_pump[`F_NEG_ANALOG_MSB:`F_NEG_ANALOG_LSB];
            amp_input_bias_sel <= in_bias_code;
            amp_output_bias_sel <=
                normal_bias_and_neg_pump[`F_OUT_BIAS_MSB:`F_OUT_BIAS_LSB];
        end
    end

    // ****************************************************************
    // Registered decoded outputs
    // ****************************************************************
    // Decoded values come from the same register as the selects, so both
    // change on one edge and a reader never sees them disagree.
    always @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            neg_gate_pump_khz_div <= 8'h32;
            analog_pump_code_mhz <= 8'h0d;
            amp_input_bias_half_x <= 6'h05;
            amp_output_bias_tenth_x <= 3'h1;
        end else begin
            neg_gate_pump_khz_div <= next_neg_gate;
            analog_pump_code_mhz <= next_analog;
            amp_input_bias_half_x <= next_in_bias;
            amp_output_bias_tenth_x <= {1'b0,
                normal_bias_and_neg_pump[`F_OUT_BIAS_MSB:`F_OUT_BIAS_LSB]} + 3'h1;
        end
    end

endmodule

// file: design/idle_timing_regs.vh
/*
 * Command codes, field positions, reset values and timing constants for the
 * idle frame timing and normal power configuration block.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef IDLE_TIMING_REGS_VH
`define IDLE_TIMING_REGS_VH

// ****************************************************************
// Command codes (register offsets)
// ****************************************************************
`define CMD_IDLE_INV_PORCH_HIGH 8'hc3
`define CMD_IDLE_PORCH_LOW 8'hc4
`define CMD_IDLE_LINE_DIVIDER 8'hc5
`define CMD_NORMAL_GATE_PUMP 8'hc6
`define CMD_NORMAL_BIAS_NEG_PUMP 8'hc7

// ****************************************************************
// Reset values
// ****************************************************************
`define RST_IDLE_INV_PORCH_HIGH 8'h00
`define RST_IDLE_PORCH_LOW 8'h21
`define RST_IDLE_LINE_DIVIDER 8'h31
`define RST_NORMAL_GATE_PUMP 8'ha9
`define RST_NORMAL_BIAS_NEG_PUMP 8'h41

// ****************************************************************
// Field positions
// ****************************************************************
`define F_INV_SEL 7
`define F_PORCH_HI_MSB 4
`define F_NEG_GATE_MSB 7
`define F_NEG_GATE_LSB 6
`define F_AUX_POS_MSB 5
`define F_AUX_POS_LSB 4
`define F_POS_GATE_MSB 3
`define F_POS_GATE_LSB 2
`define F_ANALOG_MSB 1
`define F_ANALOG_LSB 0
`define F_IN_BIAS_MSB 6
`define F_IN_BIAS_LSB 4
`define F_OUT_BIAS_MSB 3
`define F_OUT_BIAS_LSB 2
`define F_NEG_ANALOG_MSB 1
`define F_NEG_ANALOG_LSB 0

// ****************************************************************
// Timing and limits
// ****************************************************************
`define MIN_PORCH 13'h0004
`define MIN_LINE_DIVIDER 8'h28
`define PANEL_LINES 390
`define TCON_CLK_VALUE 400
`define TCON_CLK_SCALE 1000000
`define NORMAL_PORCH_DEFAULT 13'h0020
`define NORMAL_DIVIDER_DEFAULT 8'h30

`endif

// file: dv/host_model.sv
/* Host model: sends a command byte, then one parameter byte.
   Assumes a free-running mclk; everything changes on falling edges. */
`timescale 1ns/100ps
module host_model (
    input wire logic mclk,
    output logic cmd_param_select,
    output logic write_strobe_n,
    output logic [7:0] data_in
);
    // ****************
    // Byte transfers
    // ****************
    initial begin
        cmd_param_select = 1'b0;
        write_strobe_n = 1'b1;
        data_in = 8'h00;
    end
    // Strobe low one cycle, then high; data held across the rise
    task automatic send_byte(input logic dc, input logic [7:0] b, input int gap);
        @(negedge mclk);
        cmd_param_select = dc;
        data_in = b;
        write_strobe_n = 1'b0;
        @(negedge mclk);
        write_strobe_n = 1'b1;
        repeat (gap) @(negedge mclk);
    endtask
    // Bus driven to the complement after the pair, so a stale byte cannot pass for a held one
    task automatic write_reg(input logic [7:0] c, input logic [7:0] p, input int gap);
        send_byte(1'b0, c, gap);
        send_byte(1'b1, p, gap);
        @(negedge mclk);
        data_in = ~p;
    endtask
endmodule

// file: dv/idle_cfg_asserts.sv
/* Checker for the idle timing and power configuration block.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/100ps
`include "idle_timing_regs.vh"
module idle_cfg_asserts (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic cmd_param_select,
    input wire logic write_strobe_n,
    input wire logic idle_mode,
    input wire logic [7:0] data_in,
    input wire logic [7:0] line_divider,
    input wire logic [7:0] neg_gate_pump_khz_div,
    input wire logic [7:0] analog_pump_code_mhz,
    input wire logic dot_inversion,
    input wire logic setting_illegal,
    input wire logic line_tick,
    input wire logic frame_tick,
    input wire logic [12:0] porch_length,
    input wire logic [1:0] neg_gate_pump_clock_sel,
    input wire logic [1:0] aux_pos_gate_pump_clock_sel,
    input wire logic [1:0] pos_gate_pump_clock_sel,
    input wire logic [1:0] analog_pump_clock_sel,
    input wire logic [1:0] neg_analog_pump_clock_sel,
    input wire logic [1:0] amp_output_bias_sel,
    input wire logic [2:0] amp_input_bias_sel,
    input wire logic [2:0] amp_output_bias_tenth_x,
    input wire logic [5:0] amp_input_bias_half_x
);
    // ****************
    // Write tracking
    // ****************
    localparam logic [7:0] GK [4] = '{8'h5a, 8'h43, 8'h32, 8'h2d};
    localparam logic [7:0] PM [4] = '{8'h12, 8'h0d, 8'h0a, 8'h05};
    logic prev_n, armed;
    logic [7:0] cmd, wr_data;
    wire take = write_strobe_n && !prev_n;
    wire take_p = take && cmd_param_select && armed;
    wire ok_cmd = cmd >= `CMD_IDLE_INV_PORCH_HIGH && cmd <= `CMD_NORMAL_BIAS_NEG_PUMP;
    wire [7:0] sels = {neg_gate_pump_clock_sel, aux_pos_gate_pump_clock_sel,
        pos_gate_pump_clock_sel, analog_pump_clock_sel};
    wire [6:0] bias = {amp_input_bias_sel, amp_output_bias_sel, neg_analog_pump_clock_sel};
    wire [5:0] half_exp = (amp_input_bias_sel == 3'h0) ? 6'h00 : {3'h0, amp_input_bias_sel} + 6'h01;
    // Mirrors the strobe edge detector; only one parameter per command
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_n <= 1'b1;
            armed <= 1'b0;
            cmd <= 8'h00;
            wr_data <= 8'h00;
        end else begin
            prev_n <= write_strobe_n;
            if (take) begin
                armed <= !cmd_param_select;
                if (!cmd_param_select) cmd <= data_in;
                else wr_data <= data_in;
            end
        end
    end
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence steady_sel; $stable(sels) [*2]; endsequence
    sequence steady_bias; $stable(bias) [*2]; endsequence
    sequence steady_cfg; ($stable(porch_length) && $stable(line_divider)) [*2]; endsequence
    sequence idle_take(c); take_p && cmd == c && idle_mode ##1 idle_mode [*3]; endsequence
    pump_fields_a: assert property (
        take_p && cmd == `CMD_NORMAL_GATE_PUMP |-> ##3 sels == wr_data)
        else $error("gate pump selects differ from written byte");
    bias_fields_a: assert property (
        take_p && cmd == `CMD_NORMAL_BIAS_NEG_PUMP |-> ##3 bias == wr_data[6:0])
        else $error("bias selects differ from written byte");
    idle_high_a: assert property (
        idle_take(`CMD_IDLE_INV_PORCH_HIGH) |-> {dot_inversion, porch_length[12:8]}
        == {wr_data[7], wr_data[4:0]}) else $error("idle inversion or porch high wrong");
    idle_divider_a: assert property (
        idle_take(`CMD_IDLE_LINE_DIVIDER) |-> line_divider == wr_data)
        else $error("idle divider not applied");
    normal_hold_a: assert property (
        !idle_mode [*3] |-> dot_inversion && porch_length == `NORMAL_PORCH_DEFAULT
        && line_divider == `NORMAL_DIVIDER_DEFAULT)
        else $error("normal timing not applied");
    illegal_flag_a: assert property (
        steady_cfg |-> setting_illegal == (porch_length < `MIN_PORCH
        || line_divider < `MIN_LINE_DIVIDER))
        else $error("illegal setting flag wrong");
    stray_param_a: assert property (
        take && cmd_param_select && !(armed && ok_cmd) |=> $stable({sels, bias}) [*3])
        else $error("unpaired parameter changed a setting");
    pump_decode_a: assert property (
        steady_sel |-> neg_gate_pump_khz_div == GK[neg_gate_pump_clock_sel]
        && analog_pump_code_mhz == PM[analog_pump_clock_sel]) else $error("pump decode wrong");
    bias_decode_a: assert property (
        steady_bias |-> amp_input_bias_half_x == half_exp
        && amp_output_bias_tenth_x == {1'b0, amp_output_bias_sel} + 3'h1)
        else $error("bias decode wrong");
    frame_pulse_a: assert property (frame_tick |=> !frame_tick)
        else $error("frame tick longer than one cycle");
    frame_on_line_a: assert property (frame_tick |-> line_tick)
        else $error("frame tick without line tick");
endmodule
bind idle_frame_rate_and_booster_clock_cfg idle_cfg_asserts i_chk (.*);

// file: dv/tb_top.sv
/* Bench top: host model, design, expected-value model and output watcher.
   Assumes the checker binds itself to the design. */
`timescale 1ns/100ps
`include "idle_timing_regs.vh"
module tb_top;
    // ****************
    // Signals and model
    // ****************
    localparam int LINES = 8;
    localparam logic [7:0] GK [4] = '{8'h5a, 8'h43, 8'h32, 8'h2d};
    localparam logic [7:0] PM [4] = '{8'h12, 8'h0d, 8'h0a, 8'h05};
    localparam logic [15:0] BND [8] = '{16'hc380, 16'hc403, 16'hc404, 16'hc527,
        16'hc528, 16'hc31f, 16'hc5ff, 16'hc300};
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic idle_mode = 1'b0;
    logic chk_req = 1'b0;
    int n_fail = 0;
    int checked = 0;
    int gap = 0;
    int fc = 0;
    int fper = 0;
    int lc = 0;
    int lper = 0;
    logic [7:0] r [5];
    logic [62:0] exp_q [$];
    wire cmd_param_select, write_strobe_n, dot_inversion, setting_illegal, line_tick, frame_tick;
    wire [7:0] data_in, line_divider, neg_gate_pump_khz_div, analog_pump_code_mhz;
    wire [12:0] porch_length;
    wire [1:0] neg_gate_pump_clock_sel, aux_pos_gate_pump_clock_sel, pos_gate_pump_clock_sel;
    wire [1:0] analog_pump_clock_sel, neg_analog_pump_clock_sel, amp_output_bias_sel;
    wire [2:0] amp_input_bias_sel, amp_output_bias_tenth_x;
    wire [5:0] amp_input_bias_half_x;
    wire [62:0] obs = {dot_inversion, porch_length, line_divider, setting_illegal,
        neg_gate_pump_clock_sel, aux_pos_gate_pump_clock_sel, pos_gate_pump_clock_sel,
        analog_pump_clock_sel, neg_analog_pump_clock_sel, amp_input_bias_sel,
        amp_output_bias_sel, neg_gate_pump_khz_div, analog_pump_code_mhz,
        amp_input_bias_half_x, amp_output_bias_tenth_x};
    host_model i_host (.*);
    // Short timer so a frame at minimum porch and divider takes 960 cycles
    idle_frame_rate_and_booster_clock_cfg #(.PANEL_LINES(LINES), .TCON_DIV(1)) i_dut (.*);
    initial forever #25 mclk = ~mclk;
    // Expected outputs from the register copy and the mode
    function automatic logic [62:0] expv(input logic idle);
        logic [12:0] p;
        logic [7:0] d;
        logic [2:0] ib;
        p = idle ? {r[0][4:0], r[1]} : `NORMAL_PORCH_DEFAULT;
        d = idle ? r[2] : `NORMAL_DIVIDER_DEFAULT;
        ib = r[4][6:4];
        return {idle ? r[0][7] : 1'b1, p, d, (p < `MIN_PORCH) || (d < `MIN_LINE_DIVIDER),
            r[3], r[4][1:0], ib, r[4][3:2], GK[r[3][7:6]], PM[r[3][1:0]],
            (ib == 3'h0) ? 6'h00 : {3'h0, ib} + 6'h01, {1'b0, r[4][3:2]} + 3'h1};
    endfunction
    task automatic check(input logic [62:0] seen, input logic [62:0] want);
        checked++;
        if (seen !== want) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    // Let the write settle, then queue the note for the watcher
    task automatic expect_now();
        repeat (3) @(negedge mclk);
        exp_q.push_back(expv(idle_mode));
        chk_req = 1'b1;
        @(negedge mclk);
        chk_req = 1'b0;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] p);
        i_host.write_reg(c, p, gap);
        if (c >= `CMD_IDLE_INV_PORCH_HIGH && c <= `CMD_NORMAL_BIAS_NEG_PUMP)
            r[c - `CMD_IDLE_INV_PORCH_HIGH] = p;
        expect_now();
    endtask
    task automatic do_reset();
        sys_rst = 1'b1;
        r = '{`RST_IDLE_INV_PORCH_HIGH, `RST_IDLE_PORCH_LOW, `RST_IDLE_LINE_DIVIDER,
            `RST_NORMAL_GATE_PUMP, `RST_NORMAL_BIAS_NEG_PUMP};
        idle_mode = 1'b0;
        repeat (4) @(negedge mclk);
        sys_rst = 1'b0;
        expect_now();
        idle_mode = 1'b1;
        expect_now();
    endtask
    task automatic finish_test();
        if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************
    // Watcher, frame timer, watchdog
    // ****************
    always @(posedge mclk) begin
        if (chk_req) check(obs, exp_q.pop_front());
        fc <= frame_tick ? 1 : fc + 1;
        if (frame_tick) fper <= fc;
        lc <= line_tick ? 1 : lc + 1;
        if (line_tick) lper <= lc;
    end
    initial begin
        #(40000 * 50);
        n_fail++;
        finish_test();
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        void'($urandom(65));
        do_reset();
        // Every code of every power field; bias bit 7 set and ignored
        for (int i = 0; i < 8; i++) begin
            gap = i % 3;
            wr(`CMD_NORMAL_GATE_PUMP, 8'(i % 4) * 8'h55);
            wr(`CMD_NORMAL_BIAS_NEG_PUMP, {1'b1, 3'(i), 2'(i), 2'(7 - i)});
        end
        foreach (BND[k]) wr(BND[k][15:8], BND[k][7:0]);
        idle_mode = 1'b0;
        expect_now();
        i_host.send_byte(1'b1, 8'h5a, 0);
        expect_now();
        wr(8'hc8, 8'h00);
        // Random writes in both modes
        for (int i = 0; i < 24; i++) begin
            idle_mode = 1'($urandom);
            gap = $urandom % 3;
            wr(8'hc3 + 8'($urandom % 5), 8'($urandom));
        end
        do_reset();
        wr(8'hc4, 8'h04);
        wr(8'hc5, 8'h28);
        repeat (6500) @(negedge mclk);
        check(63'(fper), 63'((2 * LINES + 2 * 4) * 40));
        check(63'(lper), 63'(`MIN_LINE_DIVIDER));
        finish_test();
    end
endmodule
